// ==== move_exec.sv ====
/*
 * Execution of the data-move instructions of a small 8-bit core: file copy,
 * indirect load through two 16-bit pointers, literal to bank select and
 * literal to the working register.
 * Assumes the core has already fetched the file operand into the request,
 * that data memory answers a read one clock after it is issued, and that
 * every port is on i_ref_clk.
 */
`timescale 1ns/1ns

`include "move_exec_defines.svh"

module move_exec
(
	// clock and reset
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_rst,
	// instruction request
	input  wire logic                       i_req_valid,
	input  wire move_exec_pkg::move_req_s   i_req,
	output logic                            o_req_ready,
	// pointer load from the core
	input  wire move_exec_pkg::ptr_load_s   i_ptr_load,
	// data memory read
	output move_exec_pkg::mem_rd_s          o_mem_rd,
	input  wire logic [`MX_DATA_W-1:0]      i_mem_rdata,
	// file register write back
	output move_exec_pkg::file_wr_s         o_file_wr,
	// architectural state
	output logic [`MX_DATA_W-1:0]           o_acc,
	output logic [`MX_BANK_W-1:0]           o_bank_select_reg,
	output logic                            o_zero,
	output move_exec_pkg::ptr_bank_t        o_indirect_pointer,
	output logic                            o_done
);
	import move_exec_pkg::*;

	//--------------------------------------------------------------
	// helpers
	//--------------------------------------------------------------
	// one step of a pointer, wrapping in 16 bits
	function automatic logic [`MX_PTR_W-1:0] ptr_step
	(
		input logic [`MX_PTR_W-1:0]  ptr,
		input logic                  down
	);
		ptr_step = down ? ptr - `MX_PTR_STEP : ptr + `MX_PTR_STEP;
	endfunction

	function automatic logic is_zero
	(
		input logic [`MX_DATA_W-1:0] v
	);
		is_zero = (v == `MX_ZERO_BYTE);
	endfunction

	//--------------------------------------------------------------
	// state
	//--------------------------------------------------------------
	exec_state_s               cur;
	exec_state_s               next_cur;
	logic                      take;
	logic [`MX_PTR_W-1:0]      sel_ptr;
	logic [`MX_PTR_W-1:0]      stepped;
	logic [`MX_PTR_W-1:0]      rel_ofs;
	logic                      step_down;
	logic                      step_pre;

	assign o_req_ready = (cur.state == st_idle);
	assign take        = i_req_valid && o_req_ready;
	assign sel_ptr     = cur.indirect_pointer[i_req.ptr_sel];
	assign step_down   = i_req.pointer_mode_field[0];
	assign step_pre    = !i_req.pointer_mode_field[1];
	assign stepped     = ptr_step(sel_ptr, step_down);
	assign rel_ofs     = {{(`MX_PTR_W-`MX_OFS_W){i_req.offset[`MX_OFS_W-1]}}, i_req.offset};

	//--------------------------------------------------------------
	// pointer load decode
	//--------------------------------------------------------------
	logic [`MX_NUM_PTR-1:0]    ptr_hit;
	genvar                     g;

	generate
		for (g = 0; g < `MX_NUM_PTR; g++)
		begin : g_ptr_hit
			assign ptr_hit[g] = i_ptr_load.en && (i_ptr_load.sel == 1'(g));
		end
	endgenerate

	//--------------------------------------------------------------
	// next state
	//--------------------------------------------------------------
	always_comb
	begin
		next_cur             = cur;
		next_cur.file_wr.en  = 1'b0;
		next_cur.mem_rd.en   = 1'b0;
		next_cur.done        = 1'b0;

		// external pointer loads, one per pointer
		for (int p = 0; p < `MX_NUM_PTR; p++)
		begin
			if (ptr_hit[p])
			begin
				next_cur.indirect_pointer[p] = i_ptr_load.value;
			end
		end

		case (cur.state)
			st_idle:
			begin
				if (take)
				begin
					case (i_req.op)
						file_copy_op:
						begin
							if (i_req.dest)
							begin
								next_cur.file_wr.en   = 1'b1;
								next_cur.file_wr.addr = i_req.file_addr;
								next_cur.file_wr.data = i_req.file_data;
							end
							else
							begin
								next_cur.acc = i_req.file_data;
							end
							next_cur.zero = is_zero(i_req.file_data);
							next_cur.done = 1'b1;
						end
						indirect_load_op:
						begin
							next_cur.mem_rd.en   = 1'b1;
							next_cur.mem_rd.addr = step_pre ? stepped : sel_ptr;
							// the step wins over a core load of the same pointer
							next_cur.indirect_pointer[i_req.ptr_sel] = stepped;
							next_cur.state       = st_read;
						end
						indirect_rel_op:
						begin
							next_cur.mem_rd.en   = 1'b1;
							next_cur.mem_rd.addr = sel_ptr + rel_ofs;
							next_cur.state       = st_read;
						end
						literal_to_bank_op:
						begin
							next_cur.bank_select_reg = i_req.literal[`MX_BANK_W-1:0];
							next_cur.done            = 1'b1;
						end
						literal_to_acc_op:
						begin
							next_cur.acc  = i_req.literal;
							next_cur.done = 1'b1;
						end
						default:
						begin
							// no operation: taken, nothing changes
							next_cur.done = 1'b0;
						end
					endcase
				end
			end
			st_read:
			begin
				// memory answers one clock after the read strobe
				next_cur.acc   = i_mem_rdata;
				next_cur.zero  = is_zero(i_mem_rdata);
				next_cur.done  = 1'b1;
				next_cur.state = st_idle;
			end
			default:
			begin
				next_cur.state = st_idle;
			end
		endcase
	end

	//--------------------------------------------------------------
	// registers
	//--------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cur.state            <= st_idle;
			cur.acc              <= `MX_RST_ACC;
			cur.bank_select_reg  <= `MX_RST_BANK;
			cur.zero             <= `MX_RST_ZERO;
			cur.indirect_pointer <= {`MX_NUM_PTR{`MX_RST_PTR}};
			cur.file_wr          <= '0;
			cur.mem_rd           <= '0;
			cur.done             <= 1'b0;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	//--------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------
	assign o_mem_rd           = cur.mem_rd;
	assign o_file_wr          = cur.file_wr;
	assign o_acc              = cur.acc;
	assign o_bank_select_reg  = cur.bank_select_reg;
	assign o_zero             = cur.zero;
	assign o_indirect_pointer = cur.indirect_pointer;
	assign o_done             = cur.done;

endmodule // move_exec

// ==== move_exec_defines.svh ====
/*
 * Constants for the data-move execution block: widths, pointer mode codes,
 * reset values, the pointer step and the zero byte.
 * Assumes it is included by bare name from the package and the design file.
 */
`ifndef MOVE_EXEC_DEFINES_SVH
`define MOVE_EXEC_DEFINES_SVH

`define MX_DATA_W        8
`define MX_FADDR_W       7
`define MX_PTR_W         16
`define MX_BANK_W        5
`define MX_OFS_W         6
`define MX_MODE_W        2
`define MX_NUM_PTR       2

`define MX_MODE_PRE_INC  2'h0
`define MX_MODE_PRE_DEC  2'h1
`define MX_MODE_POST_INC 2'h2
`define MX_MODE_POST_DEC 2'h3

`define MX_PTR_STEP      16'h0001
`define MX_ZERO_BYTE     8'h00

`define MX_RST_ACC       8'h00
`define MX_RST_BANK      5'h00
`define MX_RST_PTR       16'h0000
`define MX_RST_ZERO      1'h0

`endif

// ==== move_exec_pkg.sv ====
/*
 * Types for the data-move execution block: operation codes, request,
 * pointer load, memory ports and the block's whole state.
 * Assumes move_exec_defines.svh is on the include path.
 */
`include "move_exec_defines.svh"

package move_exec_pkg;

	typedef enum logic [4:0]
	{
		op_none            = 5'h00,
		file_copy_op       = 5'h01,
		indirect_load_op   = 5'h02,
		indirect_rel_op    = 5'h04,
		literal_to_bank_op = 5'h08,
		literal_to_acc_op  = 5'h10
	} move_op_e;

	typedef enum logic [1:0]
	{
		st_idle = 2'h1,
		st_read = 2'h2
	} exec_state_e;

	typedef struct packed
	{
		move_op_e                    op;
		logic                        dest;
		logic [`MX_FADDR_W-1:0]      file_addr;
		logic [`MX_DATA_W-1:0]       file_data;
		logic                        ptr_sel;
		logic [`MX_MODE_W-1:0]       pointer_mode_field;
		logic [`MX_OFS_W-1:0]        offset;
		logic [`MX_DATA_W-1:0]       literal;
	} move_req_s;

	typedef struct packed
	{
		logic                        en;
		logic                        sel;
		logic [`MX_PTR_W-1:0]        value;
	} ptr_load_s;

	typedef struct packed
	{
		logic                        en;
		logic [`MX_FADDR_W-1:0]      addr;
		logic [`MX_DATA_W-1:0]       data;
	} file_wr_s;

	typedef struct packed
	{
		logic                        en;
		logic [`MX_PTR_W-1:0]        addr;
	} mem_rd_s;

	typedef logic [`MX_NUM_PTR-1:0][`MX_PTR_W-1:0] ptr_bank_t;

	typedef struct packed
	{
		exec_state_e                 state;
		logic [`MX_DATA_W-1:0]       acc;
		logic [`MX_BANK_W-1:0]       bank_select_reg;
		logic                        zero;
		ptr_bank_t                   indirect_pointer;
		file_wr_s                    file_wr;
		mem_rd_s                     mem_rd;
		logic                        done;
	} exec_state_s;

endpackage

// ==== move_exec_sva.sv ====
/*
 * Assertions for the data-move execution block, bound to move_exec.
 * Assumes the move_exec_pkg types and a single clock domain.
 */
`timescale 1ns/1ns
`include "move_exec_defines.svh"
module move_exec_sva
(
	// watched ports
	input wire logic                       i_ref_clk,
	input wire logic                       i_rst,
	input wire logic                       i_req_valid,
	input wire move_exec_pkg::move_req_s   i_req,
	input wire logic                       o_req_ready,
	input wire move_exec_pkg::ptr_load_s   i_ptr_load,
	input wire move_exec_pkg::mem_rd_s     o_mem_rd,
	input wire logic [`MX_DATA_W-1:0]      i_mem_rdata,
	input wire move_exec_pkg::file_wr_s    o_file_wr,
	input wire logic [`MX_DATA_W-1:0]      o_acc,
	input wire logic [`MX_BANK_W-1:0]      o_bank_select_reg,
	input wire logic                       o_zero,
	input wire move_exec_pkg::ptr_bank_t   o_indirect_pointer,
	input wire logic                       o_done
);
	import move_exec_pkg::*;
	// ----------------------------------------
	// taken request, no concurrent pointer load
	// ----------------------------------------
	wire tk = i_req_valid && o_req_ready && !i_ptr_load.en;
	wire ind = tk && i_req.op == indirect_load_op;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	a_copy_to_acc: assert property (tk && i_req.op == file_copy_op && !i_req.dest |=>
		o_done && o_acc == $past(i_req.file_data)) else $error("copy to acc wrong");
	a_copy_to_file: assert property (tk && i_req.op == file_copy_op && i_req.dest |=>
		o_file_wr.en && o_file_wr.data == $past(i_req.file_data)
		&& o_file_wr.addr == $past(i_req.file_addr)) else $error("copy to file wrong");
	a_copy_zero: assert property (tk && i_req.op == file_copy_op |=>
		o_zero == ($past(i_req.file_data) == 8'h00)) else $error("copy zero wrong");
	a_ind_result: assert property (ind || tk && i_req.op == indirect_rel_op |=>
		o_mem_rd.en ##1 o_done && o_acc == $past(i_mem_rdata)) else $error("ind load wrong");
	a_read_busy: assert property (ind || tk && i_req.op == indirect_rel_op |=>
		!o_req_ready ##1 o_req_ready) else $error("ready during read");
	a_pre_addr: assert property (ind && !i_req.pointer_mode_field[1] |=>
		o_mem_rd.addr == o_indirect_pointer[$past(i_req.ptr_sel)]) else $error("pre addr");
	a_post_addr: assert property (ind && i_req.pointer_mode_field[1] |=>
		o_mem_rd.addr == $past(o_indirect_pointer[i_req.ptr_sel])) else $error("post addr");
	a_step_wrap: assert property (ind |=> o_indirect_pointer[$past(i_req.ptr_sel)] ==
		$past(o_indirect_pointer[i_req.ptr_sel])
		+ ($past(i_req.pointer_mode_field[0]) ? 16'hffff : 16'h0001)) else $error("step");
	a_rel_addr: assert property (tk && i_req.op == indirect_rel_op |=>
		o_mem_rd.addr == $past(o_indirect_pointer[i_req.ptr_sel])
		+ $past({{10{i_req.offset[5]}}, i_req.offset})
		&& $stable(o_indirect_pointer)) else $error("rel addr");
	a_bank_load: assert property (tk && i_req.op == literal_to_bank_op |=> o_done
		&& o_bank_select_reg == $past(i_req.literal[4:0]) && $stable(o_zero)) else $error("bank");
	a_acc_literal: assert property (tk && i_req.op == literal_to_acc_op |=> o_done
		&& o_acc == $past(i_req.literal) && $stable(o_zero)) else $error("literal");
endmodule // move_exec_sva

bind move_exec move_exec_sva u_sva (.i_ref_clk, .i_rst, .i_req_valid, .i_req, .o_req_ready,
	.i_ptr_load, .o_mem_rd, .i_mem_rdata, .o_file_wr, .o_acc, .o_bank_select_reg, .o_zero,
	.o_indirect_pointer, .o_done);

// ==== tb_move_exec.sv ====
/*
 * Self-checking testbench for move_exec.
 * Assumes the checker file is compiled alongside and binds itself.
 */
`timescale 1ns/1ns
module tb_move_exec;
	import move_exec_pkg::*;
	logic             i_ref_clk;
	logic             i_rst;
	logic             i_req_valid;
	move_req_s        i_req;
	ptr_load_s        i_ptr_load;
	logic [7:0]       i_mem_rdata;
	logic             o_req_ready;
	mem_rd_s          o_mem_rd;
	mem_rd_s          m;
	file_wr_s         o_file_wr;
	file_wr_s         fr;
	logic             rdy;
	logic [7:0]       o_acc;
	logic [4:0]       o_bank_select_reg;
	logic             o_zero;
	ptr_bank_t        o_indirect_pointer;
	logic             o_done;
	int               n_fail = 0;
	int               checked = 0;
	logic [1:0]       md [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
	logic [15:0]      ea [4] = '{16'hffff, 16'h0000, 16'h0000, 16'hffff};
	logic [15:0]      ep [4] = '{16'hffff, 16'h0000, 16'hffff, 16'h0000};

	move_exec u_dut (.i_ref_clk, .i_rst, .i_req_valid, .i_req, .o_req_ready, .i_ptr_load,
		.o_mem_rd, .i_mem_rdata, .o_file_wr, .o_acc, .o_bank_select_reg, .o_zero,
		.o_indirect_pointer, .o_done);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic print_verdict();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e)
		begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask

	function automatic move_req_s mk(move_op_e op, logic [7:0] d, logic s, logic [1:0] md,
		logic [5:0] o);
		mk = '0;
		mk.op = op;
		mk.dest = s;
		mk.ptr_sel = s;
		mk.file_addr = 7'h3c;
		mk.file_data = d;
		mk.literal = d;
		mk.pointer_mode_field = md;
		mk.offset = o;
	endfunction

	// present one request, then wait for completion
	task automatic run(input move_req_s r, input logic [7:0] rd);
		int n;
		@(posedge i_ref_clk);
		i_req_valid <= 1'b1;
		i_req <= r;
		i_mem_rdata <= rd;
		@(posedge i_ref_clk);
		i_req_valid <= 1'b0;
		#1;
		m = o_mem_rd;
		fr = o_file_wr;
		rdy = o_req_ready;
		for (n = 0; n < 4 && o_done !== 1'b1; n++)
			@(posedge i_ref_clk) #1;
		if (n == 4)
		begin
			n_fail++;
			print_verdict();
		end
	endtask

	task automatic ld(input logic s, input logic [15:0] v);
		@(posedge i_ref_clk);
		i_ptr_load <= '{1'b1, s, v};
		@(posedge i_ref_clk);
		i_ptr_load <= '0;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_copy();
		run(mk(file_copy_op, 8'h00, 1'b0, 2'h0, 6'h00), 8'h00);
		chk(o_acc, 16'h0000);
		chk(o_zero, 16'h0001);
		run(mk(file_copy_op, 8'ha5, 1'b0, 2'h0, 6'h00), 8'h00);
		chk({fr.en, o_acc}, 16'h00a5);
		chk(o_zero, 16'h0000);
		chk(rdy, 16'h0001);
		run(mk(file_copy_op, 8'h00, 1'b1, 2'h0, 6'h00), 8'h00);
		chk(o_zero, 16'h0001);
		run(mk(file_copy_op, 8'h5a, 1'b1, 2'h0, 6'h00), 8'h00);
		chk({fr.en, fr.addr, fr.data}, {1'b1, 7'h3c, 8'h5a});
		chk(o_acc, 16'h00a5);
		chk(o_zero, 16'h0000);
	endtask

	task automatic t_lit();
		run(mk(literal_to_acc_op, 8'hff, 1'b0, 2'h0, 6'h00), 8'h00);
		chk(o_acc, 16'h00ff);
		run(mk(file_copy_op, 8'h00, 1'b1, 2'h0, 6'h00), 8'h00);
		run(mk(literal_to_bank_op, 8'hff, 1'b0, 2'h0, 6'h00), 8'h00);
		chk(o_bank_select_reg, 16'h001f);
		chk(o_zero, 16'h0001);
		run(mk(literal_to_acc_op, 8'h5a, 1'b0, 2'h0, 6'h00), 8'h00);
		chk({o_acc, 7'h00, o_zero}, 16'h5a01);
	endtask

	task automatic t_ind();
		ld(1'b0, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			run(mk(indirect_load_op, 8'h00, 1'b0, md[i], 6'h00), 8'(i * 17 + 1));
			chk(m.en, 16'h0001);
			chk(rdy, 16'h0000);
			chk(m.addr, ea[i]);
			chk(o_indirect_pointer[0], ep[i]);
			chk(o_acc, 16'(i * 17 + 1));
			chk(o_req_ready, 16'h0001);
		end
	endtask

	task automatic t_rel();
		ld(1'b1, 16'h0010);
		run(mk(indirect_rel_op, 8'h00, 1'b1, 2'h0, 6'h20), 8'h77);
		chk(m.addr, 16'hfff0);
		chk(o_acc, 16'h0077);
		run(mk(indirect_rel_op, 8'h00, 1'b1, 2'h0, 6'h1f), 8'h00);
		chk(m.addr, 16'h002f);
		chk(o_indirect_pointer[1], 16'h0010);
	endtask

	initial
	begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end

	initial
	begin
		i_rst = 1'b1;
		i_req_valid = 1'b0;
		i_req = '0;
		i_ptr_load = '0;
		i_mem_rdata = 8'h00;
		repeat (4) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		t_copy();
		t_lit();
		t_ind();
		t_rel();
		print_verdict();
	end
endmodule // tb_move_exec
